// file: osfc_pkg.sv
// Shared constants and types for the optical sample FIFO controller
package osfc_pkg;

    localparam int IDX_W = 7;
    localparam int TAG_W = 5;
    localparam int VAL_W = 19;
    localparam int ITEM_W = 24;
    localparam int DEPTH = 128;

    // Register offsets
    localparam logic [7:0] OFS_FLAGS = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h03;
    localparam logic [7:0] OFS_PUSH_IDX = 8'h04;
    localparam logic [7:0] OFS_POP_IDX = 8'h05;
    localparam logic [7:0] OFS_LOST = 8'h06;
    localparam logic [7:0] OFS_OCC = 8'h07;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_WMARK = 8'h09;
    localparam logic [7:0] OFS_QCTRL = 8'h0a;

    // Field positions
    localparam int FLG_A_FULL = 7;
    localparam int FLG_DATA_RDY = 6;
    localparam int MSK_A_FULL_EN = 7;
    localparam int MSK_DATA_RDY_EN = 6;
    localparam int QC_TS_EN = 5;
    localparam int QC_FLUSH = 4;
    localparam int QC_STAT_CLR = 3;
    localparam int QC_AF_TYPE = 2;
    localparam int QC_ROLLOVER = 1;

    // Values after reset
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [6:0] RST_IDX = 7'h00;
    localparam logic [7:0] RST_OCC = 8'h00;

    // Counts and limits
    localparam logic [7:0] OCC_FULL = 8'h80;
    localparam logic [6:0] LOST_MAX = 7'h7f;
    localparam logic [2:0] TS_LAST_PERIOD = 3'h7;
    localparam logic [1:0] BYTE_LAST = 2'h2;
    localparam logic [4:0] SLOT_FIRST = 5'h01;

    // Tags
    localparam logic [4:0] TAG_INVALID = 5'h1e;
    localparam logic [4:0] TAG_TSTAMP = 5'h1f;

    typedef struct packed {
        logic [TAG_W-1:0] tag;
        logic [VAL_W-1:0] value;
    } osfc_item_t;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } osfc_req_t;

endpackage

// file: osfc_sync2.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ns
module osfc_sync2 (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_ff;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_ff <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta_ff <= d_i;
            q_o <= meta_ff;
        end
    end
endmodule

// file: osfc_fifo_ctrl.sv
// Optical sample FIFO controller with host register port on the link clock
//
// How it works
// - Write index, 7 bits, steps once per pushed item and wraps 0x7F to 0.
// - Read index, 7 bits, steps once per item read and wraps 0x7F to 0.
// - Host may write the read index to rewind and re-read items.
// - Lost items counted in a 7-bit counter that sticks at 0x7F.
// - A completed pop that advances the read index zeroes the lost count.
// - Occupancy count rises on push and falls on each item read.
// - Items leave as three data-port byte reads; third byte advances index.
// - Item holds 5-bit tag in bits 23:19 and value in bits 18:0.
// - Conversions enter in slot order tagged by slot, repeating each period.
// - Almost-full flag sets when occupancy reaches 128 minus watermark.
// - Almost-full flag drives interrupt pin when its enable bit is set.
// - Reading the status register clears the almost-full flag.
// - Full push overwrites oldest with rollover set, else is dropped.
// - Type low re-flags every sample; type high only on fresh condition.
// - Clear option high lets data reads clear almost-full and data-ready.
// - Flush empties FIFO, zeroes indices and counters, clears itself.
// - With time stamping on, a time-stamp item is pushed every 8 periods.
// - Reading an empty FIFO returns an item tagged 11110 as invalid.
// - Time-stamp items carry tag 11111.
`timescale 1ns/1ns
module osfc_fifo_ctrl (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic lnk_clk_i,
    input wire logic smp_valid_i,
    input wire logic [18:0] smp_value_i,
    input wire logic smp_last_i,
    input wire logic lnk_req_i,
    input wire logic lnk_wr_i,
    input wire logic [7:0] lnk_addr_i,
    input wire logic [7:0] lnk_wdata_i,
    output logic lnk_busy_o,
    output logic lnk_done_o,
    output logic [7:0] lnk_rdata_o,
    output logic int_b_o
);

    function automatic logic a_full_cond(input logic [7:0] occ,
                                         input logic [6:0] wmark);
        a_full_cond = occ >= (osfc_pkg::OCC_FULL - {1'b0, wmark});
    endfunction

    // Link domain: capture a request and wait for its answer
    osfc_pkg::osfc_req_t req_ff;
    logic req_tgl_ff;
    logic ack_sync;
    logic ack_seen_ff;
    logic [7:0] rdata_ff;
    logic ack_tgl_ff;

    always_ff @(posedge lnk_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            req_ff <= '0;
            req_tgl_ff <= 1'b0;
            lnk_busy_o <= 1'b0;
        end else if (lnk_req_i && !lnk_busy_o) begin
            req_ff.wr <= lnk_wr_i;
            req_ff.addr <= lnk_addr_i;
            req_ff.wdata <= lnk_wdata_i;
            req_tgl_ff <= ~req_tgl_ff;
            lnk_busy_o <= 1'b1;
        end else if (ack_sync != ack_seen_ff) begin
            lnk_busy_o <= 1'b0;
        end
    end

    osfc_sync2 u_ack_sync (
        .clk_i(lnk_clk_i),
        .rst_b_i(rst_b_i),
        .d_i(ack_tgl_ff),
        .q_o(ack_sync)
    );

    always_ff @(posedge lnk_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_seen_ff <= 1'b0;
            lnk_done_o <= 1'b0;
            lnk_rdata_o <= osfc_pkg::RST_REG8;
        end else begin
            ack_seen_ff <= ack_sync;
            lnk_done_o <= ack_sync != ack_seen_ff;
            if (ack_sync != ack_seen_ff) begin
                lnk_rdata_o <= rdata_ff;
            end
        end
    end

    // System domain: detect a new request; its fields stay still while busy
    logic req_sync;
    logic req_seen_ff;
    logic acc_go;

    osfc_sync2 u_req_sync (
        .clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .d_i(req_tgl_ff),
        .q_o(req_sync)
    );

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            req_seen_ff <= 1'b0;
        end else begin
            req_seen_ff <= req_sync;
        end
    end

    assign acc_go = req_sync != req_seen_ff;

    logic rd_go;
    logic wr_go;
    logic stat_rd;
    logic data_rd;
    assign rd_go = acc_go && !req_ff.wr;
    assign wr_go = acc_go && req_ff.wr;
    assign stat_rd = rd_go && req_ff.addr == osfc_pkg::OFS_FLAGS;
    assign data_rd = rd_go && req_ff.addr == osfc_pkg::OFS_DATA;

    // Configuration registers
    logic [7:0] mask_ff;
    logic [6:0] wmark_ff;
    logic ts_en_ff;
    logic stat_clr_ff;
    logic af_type_ff;
    logic rollover_ff;
    logic flush;

    assign flush = wr_go && req_ff.addr == osfc_pkg::OFS_QCTRL
                   && req_ff.wdata[osfc_pkg::QC_FLUSH];

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_ff <= osfc_pkg::RST_REG8;
            wmark_ff <= osfc_pkg::RST_IDX;
            ts_en_ff <= 1'b0;
            stat_clr_ff <= 1'b0;
            af_type_ff <= 1'b0;
            rollover_ff <= 1'b0;
        end else if (wr_go) begin
            case (req_ff.addr)
                osfc_pkg::OFS_MASK: begin
                    mask_ff <= req_ff.wdata;
                end
                osfc_pkg::OFS_WMARK: begin
                    wmark_ff <= req_ff.wdata[6:0];
                end
                osfc_pkg::OFS_QCTRL: begin
                    ts_en_ff <= req_ff.wdata[osfc_pkg::QC_TS_EN];
                    stat_clr_ff <= req_ff.wdata[osfc_pkg::QC_STAT_CLR];
                    af_type_ff <= req_ff.wdata[osfc_pkg::QC_AF_TYPE];
                    rollover_ff <= req_ff.wdata[osfc_pkg::QC_ROLLOVER];
                end
                default: begin
                end
            endcase
        end
    end

    // Slot tagging and time-stamp scheduling
    logic [4:0] slot_ff;
    logic [2:0] period_ff;
    logic [18:0] tstamp_ff;
    logic ts_pend_ff;
    logic ts_push;

    assign ts_push = ts_pend_ff && !smp_valid_i;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            slot_ff <= osfc_pkg::SLOT_FIRST;
            period_ff <= 3'h0;
            tstamp_ff <= 19'h00000;
        end else if (smp_valid_i) begin
            if (smp_last_i) begin
                slot_ff <= osfc_pkg::SLOT_FIRST;
                period_ff <= period_ff + 3'h1;
                tstamp_ff <= tstamp_ff + 19'h00001;
            end else begin
                slot_ff <= slot_ff + 5'h01;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ts_pend_ff <= 1'b0;
        end else if (smp_valid_i && smp_last_i && ts_en_ff
                     && period_ff == osfc_pkg::TS_LAST_PERIOD) begin
            ts_pend_ff <= 1'b1;
        end else if (ts_push || flush || !ts_en_ff) begin
            ts_pend_ff <= 1'b0;
        end
    end

    osfc_pkg::osfc_item_t push_item;
    always_comb begin
        if (smp_valid_i) begin
            push_item.tag = slot_ff;
            push_item.value = smp_value_i;
        end else begin
            push_item.tag = osfc_pkg::TAG_TSTAMP;
            push_item.value = tstamp_ff;
        end
    end

    // Queue state
    osfc_pkg::osfc_item_t mem [osfc_pkg::DEPTH];
    logic [6:0] wr_ff;
    logic [6:0] rd_ff;
    logic [7:0] occ_ff;
    logic [6:0] lost_ff;
    logic [1:0] byte_ff;
    logic hold_ok_ff;
    osfc_pkg::osfc_item_t hold_ff;
    logic pop_done;
    logic push_req;
    logic push_we;
    logic [6:0] nxt_wr;
    logic [6:0] nxt_rd;
    logic [7:0] nxt_occ;
    logic [6:0] nxt_lost;

    assign push_req = smp_valid_i || ts_push;
    assign pop_done = data_rd && byte_ff == osfc_pkg::BYTE_LAST
                      && hold_ok_ff;

    always_comb begin
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_occ = occ_ff;
        nxt_lost = lost_ff;
        push_we = 1'b0;
        if (pop_done) begin
            nxt_rd = rd_ff + 7'h01;
            nxt_occ = occ_ff - 8'h01;
            nxt_lost = 7'h00;
        end
        if (wr_go && req_ff.addr == osfc_pkg::OFS_POP_IDX) begin
            nxt_rd = req_ff.wdata[6:0];
            nxt_occ = {1'b0, wr_ff - nxt_rd};
        end
        if (push_req) begin
            if (nxt_occ == osfc_pkg::OCC_FULL) begin
                if (nxt_lost != osfc_pkg::LOST_MAX) begin
                    nxt_lost = nxt_lost + 7'h01;
                end
                if (rollover_ff) begin
                    push_we = 1'b1;
                    nxt_wr = wr_ff + 7'h01;
                    nxt_rd = nxt_rd + 7'h01;
                end
            end else begin
                push_we = 1'b1;
                nxt_wr = wr_ff + 7'h01;
                nxt_occ = nxt_occ + 8'h01;
            end
        end
        if (flush) begin
            nxt_wr = osfc_pkg::RST_IDX;
            nxt_rd = osfc_pkg::RST_IDX;
            nxt_occ = osfc_pkg::RST_OCC;
            nxt_lost = osfc_pkg::RST_IDX;
            push_we = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (push_we) begin
            mem[wr_ff] <= push_item;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ff <= osfc_pkg::RST_IDX;
            rd_ff <= osfc_pkg::RST_IDX;
            occ_ff <= osfc_pkg::RST_OCC;
            lost_ff <= osfc_pkg::RST_IDX;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            occ_ff <= nxt_occ;
            lost_ff <= nxt_lost;
        end
    end

    // Data port byte sequencing
    osfc_pkg::osfc_item_t cur_item;
    always_comb begin
        if (occ_ff == osfc_pkg::RST_OCC) begin
            cur_item.tag = osfc_pkg::TAG_INVALID;
            cur_item.value = 19'h00000;
        end else begin
            cur_item = mem[rd_ff];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            byte_ff <= 2'h0;
            hold_ok_ff <= 1'b0;
            hold_ff <= '0;
        end else if (flush) begin
            byte_ff <= 2'h0;
        end else if (data_rd) begin
            if (byte_ff == 2'h0) begin
                hold_ff <= cur_item;
                hold_ok_ff <= occ_ff != osfc_pkg::RST_OCC;
            end
            if (byte_ff == osfc_pkg::BYTE_LAST) begin
                byte_ff <= 2'h0;
            end else begin
                byte_ff <= byte_ff + 2'h1;
            end
        end else if (acc_go) begin
            byte_ff <= 2'h0;
        end
    end

    // Status flags
    logic a_full_now;
    logic a_full_prev_ff;
    logic pushed_ff;
    logic a_full_ff;
    logic data_rdy_ff;
    logic af_set;
    logic flag_clr;

    assign a_full_now = a_full_cond(occ_ff, wmark_ff);
    assign af_set = af_type_ff ? (a_full_now && !a_full_prev_ff)
                               : (a_full_now && pushed_ff);
    assign flag_clr = stat_rd || (stat_clr_ff && data_rd);

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            a_full_prev_ff <= 1'b0;
            pushed_ff <= 1'b0;
        end else begin
            a_full_prev_ff <= a_full_now;
            pushed_ff <= push_we;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            a_full_ff <= 1'b0;
            data_rdy_ff <= 1'b0;
        end else begin
            a_full_ff <= af_set || (a_full_ff && !flag_clr);
            data_rdy_ff <= (smp_valid_i && push_we)
                           || (data_rdy_ff && !flag_clr);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            int_b_o <= 1'b1;
        end else begin
            int_b_o <= !((a_full_ff && mask_ff[osfc_pkg::MSK_A_FULL_EN])
                         || (data_rdy_ff
                             && mask_ff[osfc_pkg::MSK_DATA_RDY_EN]));
        end
    end

    // Read answer, captured in the same cycle as the toggle that reports it
    logic [7:0] rd_mux;
    always_comb begin
        case (req_ff.addr)
            osfc_pkg::OFS_FLAGS: begin
                rd_mux = 8'h00;
                rd_mux[osfc_pkg::FLG_A_FULL] = a_full_ff;
                rd_mux[osfc_pkg::FLG_DATA_RDY] = data_rdy_ff;
            end
            osfc_pkg::OFS_MASK: rd_mux = mask_ff;
            osfc_pkg::OFS_PUSH_IDX: rd_mux = {1'b0, wr_ff};
            osfc_pkg::OFS_POP_IDX: rd_mux = {1'b0, rd_ff};
            osfc_pkg::OFS_LOST: rd_mux = {1'b0, lost_ff};
            osfc_pkg::OFS_OCC: rd_mux = occ_ff;
            osfc_pkg::OFS_DATA: begin
                case (byte_ff)
                    2'h0: rd_mux = cur_item[23:16];
                    2'h1: rd_mux = hold_ff[15:8];
                    default: rd_mux = hold_ff[7:0];
                endcase
            end
            osfc_pkg::OFS_WMARK: rd_mux = {1'b0, wmark_ff};
            osfc_pkg::OFS_QCTRL: begin
                rd_mux = 8'h00;
                rd_mux[osfc_pkg::QC_TS_EN] = ts_en_ff;
                rd_mux[osfc_pkg::QC_STAT_CLR] = stat_clr_ff;
                rd_mux[osfc_pkg::QC_AF_TYPE] = af_type_ff;
                rd_mux[osfc_pkg::QC_ROLLOVER] = rollover_ff;
            end
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_ff <= osfc_pkg::RST_REG8;
            ack_tgl_ff <= 1'b0;
        end else if (acc_go) begin
            rdata_ff <= req_ff.wr ? 8'h00 : rd_mux;
            ack_tgl_ff <= ~ack_tgl_ff;
        end
    end

endmodule

// file: osfc_fifo_ctrl_assertions.sv
// Checker for the register port handshake and its read answers
`timescale 1ns/1ns
module osfc_fifo_ctrl_assertions (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic lnk_clk_i,
    input wire logic smp_valid_i,
    input wire logic [18:0] smp_value_i,
    input wire logic smp_last_i,
    input wire logic lnk_req_i,
    input wire logic lnk_wr_i,
    input wire logic [7:0] lnk_addr_i,
    input wire logic [7:0] lnk_wdata_i,
    input wire logic lnk_busy_o,
    input wire logic lnk_done_o,
    input wire logic [7:0] lnk_rdata_o,
    input wire logic int_b_o
);
    logic wr_ff;
    logic [7:0] addr_ff;
    logic rdone;
    assign rdone = lnk_done_o && !wr_ff;
    // Remembers what was taken so the answer can be judged
    always_ff @(posedge lnk_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ff <= 1'b0;
            addr_ff <= 8'h00;
        end else if (lnk_req_i && !lnk_busy_o) begin
            wr_ff <= lnk_wr_i;
            addr_ff <= lnk_addr_i;
        end
    end
    default clocking cb @(posedge lnk_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence take_s;
        lnk_req_i && !lnk_busy_o;
    endsequence
    sequence answer_s;
        ##[1:5] lnk_done_o;
    endsequence
    take_busy_a: assert property (take_s |=> lnk_busy_o)
        else $error("busy not raised after take");
    take_answer_a: assert property (take_s |-> answer_s)
        else $error("no answer within five link cycles");
    done_pulse_a: assert property (lnk_done_o |=> !lnk_done_o)
        else $error("done longer than one cycle");
    busy_end_a: assert property ($fell(lnk_busy_o) |-> lnk_done_o)
        else $error("busy dropped without done");
    done_busy_a: assert property (
        lnk_done_o |-> !lnk_busy_o && $past(lnk_busy_o))
        else $error("done without a pending access");
    rdata_hold_a: assert property (!lnk_done_o |-> $stable(lnk_rdata_o))
        else $error("read data moved between answers");
    write_zero_a: assert property (lnk_done_o && wr_ff |-> lnk_rdata_o == 8'h00)
        else $error("write answer not zero");
    index_width_a: assert property (
        rdone && addr_ff inside {8'h04, 8'h05, 8'h06} |-> !lnk_rdata_o[7])
        else $error("seven bit field has bit 7 set");
    occ_limit_a: assert property (
        rdone && addr_ff == 8'h07 |-> lnk_rdata_o <= 8'h80)
        else $error("occupancy above depth");
    flush_self_a: assert property (
        rdone && addr_ff == 8'h0a |-> !lnk_rdata_o[4])
        else $error("flush bit reads back set");
endmodule
bind osfc_fifo_ctrl osfc_fifo_ctrl_assertions osfc_fifo_ctrl_assertions_i (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .lnk_clk_i(lnk_clk_i),
    .smp_valid_i(smp_valid_i), .smp_value_i(smp_value_i),
    .smp_last_i(smp_last_i), .lnk_req_i(lnk_req_i), .lnk_wr_i(lnk_wr_i),
    .lnk_addr_i(lnk_addr_i), .lnk_wdata_i(lnk_wdata_i),
    .lnk_busy_o(lnk_busy_o), .lnk_done_o(lnk_done_o),
    .lnk_rdata_o(lnk_rdata_o), .int_b_o(int_b_o));

// file: osfc_host_model.sv
// Host processor model on the register port
`timescale 1ns/1ns
module osfc_host_model (
    input wire logic lnk_clk_i,
    input wire logic lnk_busy_i,
    input wire logic lnk_done_i,
    input wire logic [7:0] lnk_rdata_i,
    output logic lnk_req_o,
    output logic lnk_wr_o,
    output logic [7:0] lnk_addr_o,
    output logic [7:0] lnk_wdata_o
);
    int gap = 0;
    initial begin
        lnk_req_o = 1'b0;
        lnk_wr_o = 1'b0;
        lnk_addr_o = 8'h00;
        lnk_wdata_o = 8'h00;
    end
    // Request drops once taken so a second take cannot follow the answer
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        repeat (gap) @(posedge lnk_clk_i);
        @(posedge lnk_clk_i);
        #1;
        lnk_req_o = 1'b1;
        lnk_wr_o = wr;
        lnk_addr_o = a;
        lnk_wdata_o = d;
        do begin
            @(posedge lnk_clk_i);
            #1;
        end while (lnk_busy_i !== 1'b1);
        lnk_req_o = 1'b0;
        do begin
            @(posedge lnk_clk_i);
            #1;
            n++;
        end while (lnk_done_i !== 1'b1 && n < 8);
        q = (lnk_done_i === 1'b1) ? lnk_rdata_i : 8'hxx;
        #1;
        lnk_wr_o = ~wr;
        lnk_addr_o = ~a;
        lnk_wdata_o = ~d;
    endtask
    task automatic avail(output logic [7:0] n);
        logic [7:0] lost;
        logic [7:0] occ;
        access(1'b0, 8'h06, 8'h00, lost);
        access(1'b0, 8'h07, 8'h00, occ);
        n = (lost === 8'h00) ? occ : 8'h80;
    endtask
    task automatic pop_item(output logic [23:0] it);
        logic [7:0] b;
        for (int i = 0; i < 3; i++) begin
            access(1'b0, 8'h08, 8'h00, b);
            it = {it[15:0], b};
        end
    endtask
endmodule

// file: testbench.sv
// Self-checking bench for the optical sample FIFO controller
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    logic sys_clk_i = 1'b0;
    logic lnk_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic smp_valid_i = 1'b0;
    logic [18:0] smp_value_i = 19'h00000;
    logic smp_last_i = 1'b0;
    logic lnk_req_i, lnk_wr_i, lnk_busy_o, lnk_done_o, int_b_o;
    logic [7:0] lnk_addr_i, lnk_wdata_i, lnk_rdata_o, q, av;
    logic [23:0] exp_q[$];
    logic [23:0] it, ex;
    logic [31:0] rng = 32'h3;
    logic ro = 1'b0;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int lost = 0;
    int wp = 0;
    int rp = 0;
    int ts;
    always #5 sys_clk_i = ~sys_clk_i;
    initial begin
        #37;
        forever begin
            #62 lnk_clk_i = ~lnk_clk_i;
            #63 lnk_clk_i = ~lnk_clk_i;
        end
    end
    osfc_fifo_ctrl osfc_fifo_ctrl_i (.sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i), .lnk_clk_i(lnk_clk_i), .smp_valid_i(smp_valid_i),
        .smp_value_i(smp_value_i), .smp_last_i(smp_last_i),
        .lnk_req_i(lnk_req_i), .lnk_wr_i(lnk_wr_i), .lnk_addr_i(lnk_addr_i),
        .lnk_wdata_i(lnk_wdata_i), .lnk_busy_o(lnk_busy_o),
        .lnk_done_o(lnk_done_o), .lnk_rdata_o(lnk_rdata_o), .int_b_o(int_b_o));
    osfc_host_model osfc_host_model_i (.lnk_clk_i(lnk_clk_i),
        .lnk_busy_i(lnk_busy_o), .lnk_done_i(lnk_done_o),
        .lnk_rdata_i(lnk_rdata_o), .lnk_req_o(lnk_req_i),
        .lnk_wr_o(lnk_wr_i), .lnk_addr_o(lnk_addr_i),
        .lnk_wdata_o(lnk_wdata_i));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            test_done();
        end
    end
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        rng = xs(rng);
        osfc_host_model_i.gap = int'(rng[1:0]);
        osfc_host_model_i.access(1'b0, a, 8'h00, v);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        osfc_host_model_i.access(1'b1, a, d, q);
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        `CHK(v, e)
    endtask
    task automatic chk_state();
        chk_reg(8'h04, 8'(wp));
        chk_reg(8'h05, 8'(rp));
        chk_reg(8'h06, 8'(lost));
        chk_reg(8'h07, 8'(exp_q.size()));
    endtask
    // Expected queue after one push, full policy included
    task automatic model(input logic [4:0] tag, input logic [18:0] v);
        if (exp_q.size() == 128) begin
            lost = (lost < 127) ? lost + 1 : 127;
            if (!ro) return;
            void'(exp_q.pop_front());
            rp = (rp + 1) % 128;
        end
        exp_q.push_back({tag, v});
        wp = (wp + 1) % 128;
    endtask
    task automatic push(input int cnt, input int slots);
        logic [18:0] v;
        for (int k = 0; k < cnt; k++) begin
            rng = xs(rng);
            v = rng[18:0];
            @(posedge sys_clk_i);
            #1;
            smp_valid_i = 1'b1;
            smp_value_i = v;
            smp_last_i = (k % slots == slots - 1);
            model(5'(k % slots + 1), v);
            @(posedge sys_clk_i);
            #1;
            smp_valid_i = 1'b0;
            smp_value_i = ~v;
            smp_last_i = 1'b0;
            @(posedge sys_clk_i);
        end
    endtask
    task automatic pop_chk();
        osfc_host_model_i.pop_item(it);
        ex = exp_q.pop_front();
        `CHK(it, ex)
        rp = (rp + 1) % 128;
        lost = 0;
    endtask
    task automatic cfg(input logic [7:0] c);
        wr(8'h0a, c | 8'h10);
        ro = c[1];
        exp_q.delete();
        wp = 0;
        rp = 0;
        lost = 0;
    endtask
    task automatic wait_sys(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    initial begin
        repeat (6) @(posedge lnk_clk_i);
        @(posedge sys_clk_i);
        #1;
        rst_b_i = 1'b1;
        `CHK(int_b_o, 1'b1)
        wr(8'h07, 8'h55);
        for (int a = 0; a < 12; a++) if (a != 8) chk_reg(8'(a), 8'h00);
        rd(8'h08, q);
        `CHK(q, {5'b11110, 3'b000})
        chk_state();
        push(6, 3);
        chk_state();
        repeat (6) pop_chk();
        push(3, 3);
        rd(8'h08, q);
        rd(8'h08, q);
        chk_state();
        pop_chk();
        wr(8'h05, 8'((rp + 127) % 128));
        exp_q.push_front(ex);
        rp = (rp + 127) % 128;
        chk_state();
        repeat (3) pop_chk();
        cfg(8'h00);
        push(258, 1);
        chk_state();
        osfc_host_model_i.avail(av);
        `CHK(av, 8'h80)
        pop_chk();
        chk_state();
        cfg(8'h02);
        push(131, 1);
        chk_state();
        pop_chk();
        wr(8'h09, 8'h7c);
        wr(8'h03, 8'h80);
        chk_reg(8'h09, 8'h7c);
        chk_reg(8'h03, 8'h80);
        for (int t = 0; t < 4; t++) begin
            cfg({4'h0, t[1], t[0], 2'b00});
            rd(8'h00, q);
            push(3, 1);
            wait_sys(4);
            `CHK(int_b_o, 1'b1)
            push(1, 1);
            wait_sys(4);
            `CHK(int_b_o, 1'b0)
            rd(8'h08, q);
            wait_sys(4);
            `CHK(int_b_o, t[1])
            rd(8'h00, q);
            `CHK(q[7], !t[1])
            wait_sys(4);
            `CHK(int_b_o, 1'b1)
            push(1, 1);
            wait_sys(4);
            `CHK(int_b_o, t[0])
        end
        for (int e = 0; e < 2; e++) begin
            cfg({2'b00, e[0], 5'h00});
            push(16, 1);
            wait_sys(4);
            chk_reg(8'h07, 8'(16 + 2 * e));
            ts = 0;
            repeat (16 + 2 * e) begin
                osfc_host_model_i.pop_item(it);
                if (it[23:19] === 5'b11111) ts++;
            end
            `CHK(ts, 2 * e)
        end
        test_done();
    end
endmodule
